// [hw/adcso_params.svh]
// timing counts, widths and fixed patterns of the serial output lanes
`ifndef ADCSO_PARAMS_SVH
`define ADCSO_PARAMS_SVH

`define ADCSO_WORD_W 18
`define ADCSO_MSB 17
`define ADCSO_MSB_M1 16
`define ADCSO_CLK_PERIOD_NS 8
`define ADCSO_T_CONV_NS 78
`define ADCSO_CONV_CYC ((`ADCSO_T_CONV_NS + `ADCSO_CLK_PERIOD_NS - 1) / `ADCSO_CLK_PERIOD_NS)
`define ADCSO_CNT_W 5
`define ADCSO_EDGES_ONE 5'h12
`define ADCSO_EDGES_TWO 5'h0A
`define ADCSO_PAT_ONE 18'h281FC
`define ADCSO_PAT_TWO 18'h330FC
`define ADCSO_SYNC_W 4
`define ADCSO_IDX_CNV 0
`define ADCSO_IDX_SCLK 1
`define ADCSO_IDX_DUAL 2
`define ADCSO_IDX_PAT 3
`define ADCSO_FIFO_FULL 2'h2

`endif

// [hw/adcso_pkg.sv]
// types shared by the serial output lane logic
package adcso_pkg;
  typedef enum logic [1:0] {
    ADCSO_IDLE = 2'b00,
    ADCSO_CONV = 2'b01,
    ADCSO_PUSH = 2'b10
  } adcso_conv_e;
  typedef logic [17:0] adcso_word_t;
endpackage : adcso_pkg

// [hw/adcso_lane_out.sv]
// serial result output with one-lane, two-lane and test-pattern modes
`timescale 1ns/10ps
`include "adcso_params.svh"
// Operation
// - dual select enables second lane b
// - dual mode: two bits per edge, lanes together
// - pattern force replaces results with fixed pattern
// - single lane pattern 10 1000 0001 1111 1100
// - dual lane pattern 11 0011 0000 1111 1100
// - msb on lane a before first pulse
// - data changes each clock edge, clock echoed
module adcso_lane_out (
  input wire logic ref_clk_i, // 125 MHz core clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic convert_start_i, // rising edge starts a conversion (pin)
  input wire logic shift_clk_i, // shift clock burst from receiver (pin)
  input wire logic dual_lane_select_i, // high selects two-lane output (pin)
  input wire logic pattern_force_i, // high forces test pattern (pin)
  input wire adcso_pkg::adcso_word_t sample_i, // converter core result, same clock
  output logic lane_a_data_o, // lane a serial data
  output logic lane_b_data_o, // lane b serial data
  output logic lane_b_en_o, // lane b driver enabled
  output logic echoed_clock_out_o // echoed shift clock, edge aligned with data
);
  import adcso_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [`ADCSO_SYNC_W-1:0] sync1_reg;
  logic [`ADCSO_SYNC_W-1:0] sync2_reg;
  logic [`ADCSO_SYNC_W-1:0] pins;

  assign pins = {pattern_force_i, dual_lane_select_i, shift_clk_i, convert_start_i};

  genvar gi;
  generate
    for (gi = 0; gi < `ADCSO_SYNC_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic cnv_prev_reg;
  logic sclk_prev_reg;
  logic cnv_rise;
  logic sclk_edge;
  logic dual_now;
  logic pat_now;

  assign dual_now = sync2_reg[`ADCSO_IDX_DUAL];
  assign pat_now = sync2_reg[`ADCSO_IDX_PAT];
  assign cnv_rise = sync2_reg[`ADCSO_IDX_CNV] & ~cnv_prev_reg;
  // both edges of the shift clock move the data
  assign sclk_edge = sync2_reg[`ADCSO_IDX_SCLK] ^ sclk_prev_reg;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnv_prev_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      cnv_prev_reg <= sync2_reg[`ADCSO_IDX_CNV];
      sclk_prev_reg <= sync2_reg[`ADCSO_IDX_SCLK];
    end
  end

  // ==========================================================
  // conversion sequencer
  adcso_conv_e conv_state_reg;
  logic [`ADCSO_CNT_W-1:0] conv_cnt_reg;
  adcso_word_t sample_reg;
  logic fifo_in_ready;
  logic push;
  adcso_word_t push_word;

  assign push = (conv_state_reg == ADCSO_PUSH) && fifo_in_ready;

  // pattern chosen by the lane mode at completion time
  always_comb begin
    if (pat_now) begin
      push_word = dual_now ? `ADCSO_PAT_TWO : `ADCSO_PAT_ONE;
    end else begin
      push_word = sample_reg;
    end
  end

  // a start edge during a conversion is ignored; a full buffer stalls completion
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_state_reg <= ADCSO_IDLE;
      conv_cnt_reg <= '0;
      sample_reg <= '0;
    end else begin
      case (conv_state_reg)
        ADCSO_IDLE: begin
          if (cnv_rise) begin
            sample_reg <= sample_i;
            conv_cnt_reg <= '0;
            conv_state_reg <= ADCSO_CONV;
          end
        end
        ADCSO_CONV: begin
          conv_cnt_reg <= conv_cnt_reg + 1'b1;
          if (conv_cnt_reg == `ADCSO_CNT_W'(`ADCSO_CONV_CYC - 1)) begin
            conv_state_reg <= ADCSO_PUSH;
          end
        end
        ADCSO_PUSH: begin
          if (fifo_in_ready) begin
            conv_state_reg <= ADCSO_IDLE;
          end
        end
        default: begin
          conv_state_reg <= ADCSO_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // two-entry result buffer
  adcso_word_t fifo_mem [0:1];
  logic fifo_wr_reg;
  logic fifo_rd_reg;
  logic [1:0] fifo_cnt_reg;
  logic fifo_out_valid;
  logic pop;
  logic busy_reg;

  assign fifo_in_ready = (fifo_cnt_reg != `ADCSO_FIFO_FULL);
  assign fifo_out_valid = (fifo_cnt_reg != 2'h0);
  // next word waits until the receiver has drained the current one
  assign pop = fifo_out_valid && !busy_reg;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
      fifo_wr_reg <= 1'b0;
      fifo_rd_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem[fifo_wr_reg] <= push_word;
        fifo_wr_reg <= ~fifo_wr_reg;
      end
      if (pop) begin
        fifo_rd_reg <= ~fifo_rd_reg;
      end
      if (push && !pop) begin
        fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
      end else if (pop && !push) begin
        fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
      end
    end
  end

  // ==========================================================
  // output shifter
  adcso_word_t sr_reg;
  adcso_word_t head;
  logic dual_reg;
  logic [`ADCSO_CNT_W-1:0] edge_cnt_reg;
  logic [`ADCSO_CNT_W-1:0] edge_target;
  logic lane_a_reg;
  logic lane_b_reg;
  logic lane_b_en_reg;
  logic echo_reg;

  assign head = fifo_mem[fifo_rd_reg];
  // dual needs 5 pulses, single 9 pulses: two edges each
  assign edge_target = dual_reg ? `ADCSO_EDGES_TWO : `ADCSO_EDGES_ONE;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sr_reg <= '0;
      dual_reg <= 1'b0;
      edge_cnt_reg <= '0;
      busy_reg <= 1'b0;
      lane_a_reg <= 1'b0;
      lane_b_reg <= 1'b0;
    end else if (pop) begin
      sr_reg <= head;
      dual_reg <= dual_now;
      edge_cnt_reg <= '0;
      busy_reg <= 1'b1;
      lane_a_reg <= head[`ADCSO_MSB];
      lane_b_reg <= dual_now & head[`ADCSO_MSB_M1];
    end else if (busy_reg && sclk_edge) begin
      edge_cnt_reg <= edge_cnt_reg + 1'b1;
      if (edge_cnt_reg + 1'b1 == edge_target) begin
        busy_reg <= 1'b0;
      end
      if (dual_reg) begin
        sr_reg <= {sr_reg[`ADCSO_MSB-2:0], 2'b00};
        lane_a_reg <= sr_reg[`ADCSO_MSB-2];
        lane_b_reg <= sr_reg[`ADCSO_MSB-3];
      end else begin
        sr_reg <= {sr_reg[`ADCSO_MSB-1:0], 1'b0};
        lane_a_reg <= sr_reg[`ADCSO_MSB-1];
        lane_b_reg <= 1'b0;
      end
    end
  end

  // echo and lane b enable share the data's register stage so edges line up
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      echo_reg <= 1'b0;
      lane_b_en_reg <= 1'b0;
    end else begin
      echo_reg <= sync2_reg[`ADCSO_IDX_SCLK];
      lane_b_en_reg <= dual_now;
    end
  end

  assign lane_a_data_o = lane_a_reg;
  assign lane_b_data_o = lane_b_reg;
  assign lane_b_en_o = lane_b_en_reg;
  assign echoed_clock_out_o = echo_reg;

endmodule : adcso_lane_out

// [verification/adcso_lane_out_chk.sv]
// assertion checker for the serial output lanes
`timescale 1ns/10ps
module adcso_lane_out_chk (
  input wire logic ref_clk_i, // core clock
  input wire logic rst_b_i, // reset, active low
  input wire logic shift_clk_i, // shift clock pin
  input wire logic dual_lane_select_i, // lane mode pin
  input wire logic lane_a_data_o, // lane a
  input wire logic lane_b_data_o, // lane b
  input wire logic lane_b_en_o, // lane b enable
  input wire logic echoed_clock_out_o // echo
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ====================
  // lane mode
  AST_B_ON: assert property (dual_lane_select_i [*5] |-> lane_b_en_o)
    else $error("lane b off");
  AST_B_OFF: assert property (!dual_lane_select_i [*5] |-> !lane_b_en_o)
    else $error("lane b on");
  AST_B_QUIET: assert property (!lane_b_en_o && $changed(echoed_clock_out_o) |-> !lane_b_data_o)
    else $error("lane b busy");
  // ====================
  // echoed clock
  AST_ECHO_RISE: assert property ($rose(shift_clk_i) |-> ##[1:4] $rose(echoed_clock_out_o))
    else $error("echo rise late");
  AST_ECHO_FALL: assert property ($fell(shift_clk_i) |-> ##[1:4] $fell(echoed_clock_out_o))
    else $error("echo fall late");
  AST_ECHO_LEVEL: assert property ($stable(shift_clk_i) [*5] |-> echoed_clock_out_o == shift_clk_i)
    else $error("echo level");
  AST_ECHO_SAME: assert property ($changed(echoed_clock_out_o) |-> echoed_clock_out_o == shift_clk_i)
    else $error("echo spurious");
  AST_IDLE: assert property ($rose(rst_b_i) |-> !echoed_clock_out_o && !lane_a_data_o && !lane_b_data_o)
    else $error("outputs not idle");
endmodule : adcso_lane_out_chk
bind adcso_lane_out adcso_lane_out_chk u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .shift_clk_i(shift_clk_i),
  .dual_lane_select_i(dual_lane_select_i), .lane_a_data_o(lane_a_data_o), .lane_b_data_o(lane_b_data_o),
  .lane_b_en_o(lane_b_en_o), .echoed_clock_out_o(echoed_clock_out_o));

// [verification/adcso_link_rx.sv]
// receiver model that supplies shift clock bursts
`timescale 1ns/10ps
module adcso_link_rx (
  output logic shift_clk_o // shift clock, low between bursts
);
  initial shift_clk_o = 1'b0;
  // whole pulses only, 160 ns period
  task burst(input int n);
    repeat (n) begin
      #80 shift_clk_o = 1'b1;
      #80 shift_clk_o = 1'b0;
    end
  endtask : burst
endmodule : adcso_link_rx

// [verification/adcso_lane_out_tb.sv]
// self-checking bench for the serial output lanes
`timescale 1ns/10ps
module adcso_lane_out_tb;
  import adcso_pkg::*;
  // the monitor history starts at the idle level so reset shows no false echo edge
  logic ref_clk_i = 0, rst_b_i = 0, conv_start = 0, dual = 0, pat = 0, lane_a, lane_b, b_en, echo;
  logic pa = 0, pb = 0, pe = 0;
  wire shift_clk;
  adcso_word_t sample = '0, q[$], got;
  int n_errors = 0, comparisons = 0, seed = 32'h943598CD, nb = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  adcso_lane_out u_adcso_lane_out (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .convert_start_i(conv_start),
    .shift_clk_i(shift_clk), .dual_lane_select_i(dual), .pattern_force_i(pat), .sample_i(sample),
    .lane_a_data_o(lane_a), .lane_b_data_o(lane_b), .lane_b_en_o(b_en), .echoed_clock_out_o(echo));
  adcso_link_rx u_adcso_link_rx (.shift_clk_o(shift_clk));
  task automatic check(input adcso_word_t exp, input adcso_word_t act);
    comparisons++;
    if (act !== exp) begin
      n_errors++;
      $display("[ERR] %0t exp %h got %h", $time, exp, act);
    end
  endtask : check
  // ====================
  // monitor: the bit that stood before each echo edge
  always @(negedge ref_clk_i) begin
    if (echo !== pe) begin
      if (nb < 18) got[17 - nb] = pa;
      if (dual && nb < 18) got[16 - nb] = pb;
      nb += dual ? 2 : 1;
      if (nb == (dual ? 20 : 18)) begin
        check(q.pop_front(), got);
        nb = 0;
      end
    end
    pa = lane_a;
    pb = lane_b;
    pe = echo;
  end
  // ====================
  // four conversions fill the buffer, then all are read
  task automatic run(input logic d, input logic p);
    @(posedge ref_clk_i) #1 dual = d;
    pat = p;
    repeat (4) begin
      @(posedge ref_clk_i) #1 sample = adcso_word_t'($random(seed));
      q.push_back(p ? (d ? 18'h330FC : 18'h281FC) : sample);
      conv_start = 1'b1;
      repeat (20) @(posedge ref_clk_i);
      #1 conv_start = 1'b0;
      repeat (20) @(posedge ref_clk_i);
    end
    // bursts start just after a clock edge so no shift edge races the sampling edge
    #1 repeat (4) u_adcso_link_rx.burst(d ? 5 : 9);
    repeat (60) @(posedge ref_clk_i);
    $display("test dual %0d pattern %0d done", d, p);
  endtask : run
  task end_of_test;
    // an expected word never received, or a word cut short, is a mismatch too
    if (q.size() != 0 || nb != 0) n_errors++;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1 rst_b_i = 1'b1;
    for (int i = 0; i < 4; i++) run(i[1], i[0]);
    end_of_test();
  end
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
endmodule : adcso_lane_out_tb
